// *** rtl/alzt_zone.sv ***
`timescale 1ns/1ps
module alzt_zone
#(
  parameter int CUR_W = alzt_pkg::ALZT_CUR_W
)
(
  input wire logic i_ref_clk,            // System clock, 50 MHz.
  input wire logic i_reset_n,            // Asynchronous reset, active low.
  input wire logic [7:0] i_reg_addr,     // Register offset.
  input wire logic [7:0] i_reg_wdata,    // Register write data.
  input wire logic i_reg_wr,             // Register write strobe.
  input wire logic i_reg_rd,             // Register read strobe.
  output logic [7:0] o_reg_rdata,        // Register read data.
  input wire logic [CUR_W-1:0] i_sensor, // Sensor current, 0.54 uA steps.
  input wire logic i_sensor_valid,       // New sample strobe.
  output alzt_pkg::alzt_zone_t o_zone,   // Current backlight zone.
  output logic o_zone_change             // Zone changed last cycle.
);

  // Maps a setting code to sensor current steps.
  function automatic logic [CUR_W-1:0] code_cur(input logic [7:0] code,
                                                input int shift);
    logic [CUR_W-1:0] base;
    base = (code == alzt_pkg::ALZT_ODD_CODE) ?
           CUR_W'(alzt_pkg::ALZT_ODD_CODE_STEPS) : CUR_W'(code);
    code_cur = CUR_W'(base << shift);
  endfunction

  logic [7:0] office_thr;
  logic [7:0] office_hys;
  logic [7:0] indoor_thr;
  logic [7:0] indoor_hys;
  alzt_pkg::alzt_zone_t zone_r;
  alzt_pkg::alzt_zone_t zone_nxt;
  logic change_r;

  alzt_regs u_regs
  (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata),
    .o_office_thr(office_thr),
    .o_office_hys(office_hys),
    .o_indoor_thr(indoor_thr),
    .o_indoor_hys(indoor_hys)
  );

  //////////////////////////////////////////////////////////////////////////
  wire [CUR_W-1:0] office_thr_cur =
    code_cur(office_thr, alzt_pkg::ALZT_OFFICE_SHIFT);
  wire [CUR_W-1:0] office_hys_cur =
    code_cur(office_hys, alzt_pkg::ALZT_OFFICE_SHIFT);
  wire [CUR_W-1:0] indoor_thr_cur =
    code_cur(indoor_thr, alzt_pkg::ALZT_INDOOR_SHIFT);
  wire [CUR_W-1:0] indoor_hys_cur =
    code_cur(indoor_hys, alzt_pkg::ALZT_INDOOR_SHIFT);
  wire [CUR_W-1:0] office_exit = office_thr_cur + office_hys_cur;
  wire [CUR_W-1:0] indoor_exit = indoor_thr_cur + indoor_hys_cur;
  wire below_office = i_sensor < office_thr_cur;
  wire above_office = i_sensor > office_exit;
  wire below_indoor = i_sensor < indoor_thr_cur;
  wire above_indoor = i_sensor > indoor_exit;

  // One step per sample; a deeper zone waits for the next sample.
  always_comb
  begin
    zone_nxt = zone_r;
    if (i_sensor_valid)
    begin
      case (zone_r)
        alzt_pkg::ALZT_BRIGHT:
        begin
          if (below_office)
            zone_nxt = alzt_pkg::ALZT_OFFICE;
        end
        alzt_pkg::ALZT_OFFICE:
        begin
          if (below_indoor)
            zone_nxt = alzt_pkg::ALZT_INDOOR;
          else if (above_office)
            zone_nxt = alzt_pkg::ALZT_BRIGHT;
        end
        alzt_pkg::ALZT_INDOOR:
        begin
          if (above_indoor)
            zone_nxt = alzt_pkg::ALZT_OFFICE;
        end
        default:
          zone_nxt = alzt_pkg::ALZT_BRIGHT;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      zone_r <= alzt_pkg::ALZT_BRIGHT;
      change_r <= 1'b0;
    end
    else
    begin
      zone_r <= zone_nxt;
      change_r <= zone_nxt != zone_r;
    end
  end

  assign o_zone = zone_r;
  assign o_zone_change = change_r;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  property p_office_entry;
    i_sensor_valid && zone_r == alzt_pkg::ALZT_BRIGHT && below_office
      |=> zone_r == alzt_pkg::ALZT_OFFICE && change_r;
  endproperty
  a_office_entry: assert property (p_office_entry)
    else $error("office zone not entered below threshold");

  property p_bright_return;
    i_sensor_valid && zone_r == alzt_pkg::ALZT_OFFICE && !below_indoor &&
      i_sensor > office_thr_cur + office_hys_cur
      |=> zone_r == alzt_pkg::ALZT_BRIGHT && change_r;
  endproperty
  a_bright_return: assert property (p_bright_return)
    else $error("bright zone not restored above office exit");

  property p_office_hys_map;
    (office_hys == 8'h03 |-> office_hys_cur == 12'h010) and
    (office_hys == 8'h01 |-> office_hys_cur == 12'h004) and
    (office_hys == 8'hFF |-> office_hys_cur == 12'h3FC);
  endproperty
  a_office_hys_map: assert property (p_office_hys_map)
    else $error("office hysteresis code maps wrongly");

  property p_indoor_entry;
    i_sensor_valid && zone_r == alzt_pkg::ALZT_OFFICE &&
      i_sensor < indoor_thr_cur |=> zone_r == alzt_pkg::ALZT_INDOOR;
  endproperty
  a_indoor_entry: assert property (p_indoor_entry)
    else $error("indoor zone not entered below threshold");

  property p_indoor_thr_map;
    (indoor_thr == 8'h03 |-> indoor_thr_cur == 12'h008) and
    (indoor_thr == 8'h02 |-> indoor_thr_cur == 12'h004) and
    (indoor_thr == 8'hFF |-> indoor_thr_cur == 12'h1FE);
  endproperty
  a_indoor_thr_map: assert property (p_indoor_thr_map)
    else $error("indoor threshold code maps wrongly");

  property p_office_return;
    i_sensor_valid && zone_r == alzt_pkg::ALZT_INDOOR && above_indoor
      |=> zone_r == alzt_pkg::ALZT_OFFICE && $past(zone_r) != zone_r;
  endproperty
  a_office_return: assert property (p_office_return)
    else $error("office zone not restored above indoor exit");

  property p_indoor_hys_map;
    (indoor_hys == 8'h03 |-> indoor_hys_cur == 12'h008) and
    (indoor_hys == 8'h01 |-> indoor_hys_cur == 12'h002) and
    (indoor_hys == 8'hFF |-> indoor_hys_cur == 12'h1FE);
  endproperty
  a_indoor_hys_map: assert property (p_indoor_hys_map)
    else $error("indoor hysteresis code maps wrongly");

  property p_hold_without_sample;
    !i_sensor_valid |=> $stable(zone_r) && !change_r;
  endproperty
  a_hold_without_sample: assert property (p_hold_without_sample)
    else $error("zone moved without a sample");

  property p_hold_in_band;
    i_sensor_valid && zone_r == alzt_pkg::ALZT_INDOOR &&
      !(i_sensor > indoor_exit) |=> zone_r == alzt_pkg::ALZT_INDOOR;
  endproperty
  a_hold_in_band: assert property (p_hold_in_band)
    else $error("indoor zone left inside hysteresis band");

  // Entry is strict: a sample equal to the threshold keeps the zone.
  property p_bright_hold;
    i_sensor_valid && zone_r == alzt_pkg::ALZT_BRIGHT && !below_office
      |=> zone_r == alzt_pkg::ALZT_BRIGHT;
  endproperty
  a_bright_hold: assert property (p_bright_hold)
    else $error("bright zone left at or above office threshold");

  property p_office_hold;
    i_sensor_valid && zone_r == alzt_pkg::ALZT_OFFICE && !below_indoor &&
      !above_office |=> zone_r == alzt_pkg::ALZT_OFFICE;
  endproperty
  a_office_hold: assert property (p_office_hold)
    else $error("office zone left inside hysteresis band");

  property p_change_pulse;
    change_r == ($past(zone_r) != zone_r);
  endproperty
  a_change_pulse: assert property (p_change_pulse)
    else $error("zone change pulse does not match zone movement");

  // Bright and indoor are never neighbours in time.
  property p_one_step;
    (zone_r == alzt_pkg::ALZT_BRIGHT |=> zone_r != alzt_pkg::ALZT_INDOOR) and
    (zone_r == alzt_pkg::ALZT_INDOOR |=> zone_r != alzt_pkg::ALZT_BRIGHT);
  endproperty
  a_one_step: assert property (p_one_step)
    else $error("zone skipped the office step");

  c_to_office: cover property (zone_r == alzt_pkg::ALZT_BRIGHT ##1
                               zone_r == alzt_pkg::ALZT_OFFICE);
  c_to_indoor: cover property (zone_r == alzt_pkg::ALZT_OFFICE ##1
                               zone_r == alzt_pkg::ALZT_INDOOR);
  c_back_bright: cover property (zone_r == alzt_pkg::ALZT_OFFICE ##1
                                 zone_r == alzt_pkg::ALZT_BRIGHT);
  c_back_office: cover property (zone_r == alzt_pkg::ALZT_INDOOR ##1
                                 zone_r == alzt_pkg::ALZT_OFFICE);

endmodule // alzt_zone

// *** rtl/alzt_pkg.sv ***
package alzt_pkg;

  // Register offsets.
  localparam logic [7:0] ALZT_OFFICE_THR_OFS = 8'h34;
  localparam logic [7:0] ALZT_OFFICE_HYS_OFS = 8'h35;
  localparam logic [7:0] ALZT_INDOOR_THR_OFS = 8'h36;
  localparam logic [7:0] ALZT_INDOOR_HYS_OFS = 8'h37;

  // Reset values of the settings.
  localparam logic [7:0] ALZT_OFFICE_THR_RST = 8'h00;
  localparam logic [7:0] ALZT_OFFICE_HYS_RST = 8'h00;
  localparam logic [7:0] ALZT_INDOOR_THR_RST = 8'h00;
  localparam logic [7:0] ALZT_INDOOR_HYS_RST = 8'h00;

  // Read answer for an unmapped offset.
  localparam logic [7:0] ALZT_UNMAPPED_RD = 8'h00;

  // Sensor current is carried in steps of 0.54 uA.
  localparam int ALZT_CUR_W = 12;
  // An office code step is 2.16 uA (four steps), an indoor step 1.08 uA.
  localparam int ALZT_OFFICE_SHIFT = 2;
  localparam int ALZT_INDOOR_SHIFT = 1;
  // Code 3 breaks the linear scale: it reads as four code steps.
  localparam logic [7:0] ALZT_ODD_CODE = 8'h03;
  localparam int ALZT_ODD_CODE_STEPS = 4;

  typedef enum logic [1:0] {
    ALZT_BRIGHT,
    ALZT_OFFICE,
    ALZT_INDOOR
  } alzt_zone_t;

endpackage

// *** rtl/alzt_regs.sv ***
`timescale 1ns/1ps
module alzt_regs
(
  input wire logic i_ref_clk,           // System clock.
  input wire logic i_reset_n,           // Asynchronous reset, active low.
  input wire logic [7:0] i_reg_addr,    // Register offset.
  input wire logic [7:0] i_reg_wdata,   // Write data.
  input wire logic i_reg_wr,            // Write strobe.
  input wire logic i_reg_rd,            // Read strobe.
  output logic [7:0] o_reg_rdata,       // Read data, registered.
  output logic [7:0] o_office_thr,      // Office threshold setting.
  output logic [7:0] o_office_hys,      // Office hysteresis setting.
  output logic [7:0] o_indoor_thr,      // Indoor threshold setting.
  output logic [7:0] o_indoor_hys       // Indoor hysteresis setting.
);

  logic [7:0] office_zone_threshold_r;
  logic [7:0] office_zone_hysteresis_r;
  logic [7:0] indoor_zone_threshold_r;
  logic [7:0] indoor_zone_hysteresis_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  wire sel_othr = i_reg_addr == alzt_pkg::ALZT_OFFICE_THR_OFS;
  wire sel_ohys = i_reg_addr == alzt_pkg::ALZT_OFFICE_HYS_OFS;
  wire sel_ithr = i_reg_addr == alzt_pkg::ALZT_INDOOR_THR_OFS;
  wire sel_ihys = i_reg_addr == alzt_pkg::ALZT_INDOOR_HYS_OFS;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    if (sel_othr)
      rdata_nxt = office_zone_threshold_r;
    else if (sel_ohys)
      rdata_nxt = office_zone_hysteresis_r;
    else if (sel_ithr)
      rdata_nxt = indoor_zone_threshold_r;
    else if (sel_ihys)
      rdata_nxt = indoor_zone_hysteresis_r;
    else
      rdata_nxt = alzt_pkg::ALZT_UNMAPPED_RD;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      office_zone_threshold_r <= alzt_pkg::ALZT_OFFICE_THR_RST;
      office_zone_hysteresis_r <= alzt_pkg::ALZT_OFFICE_HYS_RST;
      indoor_zone_threshold_r <= alzt_pkg::ALZT_INDOOR_THR_RST;
      indoor_zone_hysteresis_r <= alzt_pkg::ALZT_INDOOR_HYS_RST;
    end
    else if (i_reg_wr)
    begin
      if (sel_othr)
        office_zone_threshold_r <= i_reg_wdata;
      if (sel_ohys)
        office_zone_hysteresis_r <= i_reg_wdata;
      if (sel_ithr)
        indoor_zone_threshold_r <= i_reg_wdata;
      if (sel_ihys)
        indoor_zone_hysteresis_r <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rdata_r <= alzt_pkg::ALZT_UNMAPPED_RD;
    else if (i_reg_rd)
      rdata_r <= rdata_nxt;
  end

  assign o_reg_rdata = rdata_r;
  assign o_office_thr = office_zone_threshold_r;
  assign o_office_hys = office_zone_hysteresis_r;
  assign o_indoor_thr = indoor_zone_threshold_r;
  assign o_indoor_hys = indoor_zone_hysteresis_r;

endmodule // alzt_regs

// *** test/alzt_sensor_model.sv ***
`timescale 1ns/1ps
// Phototransistor readout: one valid pulse for each requested measurement.
module alzt_sensor_model
(
  input wire logic i_ref_clk,      // System clock.
  input wire logic i_req,          // Request one measurement.
  input wire logic [11:0] i_level, // Current to report.
  output logic [11:0] o_sensor,    // Measured current.
  output logic o_valid             // New sample strobe.
);
  initial
  begin
    o_sensor = 12'hA5A;
    o_valid = 1'b0;
  end
  // Between samples the bus keeps moving so a stale value is never reused.
  always @(negedge i_ref_clk)
  begin
    o_valid <= i_req;
    o_sensor <= i_req ? i_level : ~o_sensor;
  end
endmodule // alzt_sensor_model

// *** test/alzt_zone_tb.sv ***
`timescale 1ns/1ps
module alzt_zone_tb;
  logic i_ref_clk, i_reset_n, i_reg_wr, i_reg_rd, i_sensor_valid;
  logic o_zone_change, req;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [11:0] i_sensor, level;
  alzt_pkg::alzt_zone_t o_zone, exp_zone;
  int errors, num_checks, cycles, v;
  logic [31:0] seed, r;
  logic [7:0] cfg [4];
  logic [7:0] corner [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFF};
  logic [11:0] tbl [8] = '{12'h010, 12'h00F, 12'h008, 12'h007,
                           12'h010, 12'h011, 12'h020, 12'h021};
  alzt_zone #(.CUR_W(12)) dut (.i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_sensor(i_sensor),
    .i_sensor_valid(i_sensor_valid), .o_zone(o_zone),
    .o_zone_change(o_zone_change));
  alzt_sensor_model sensor (.i_ref_clk(i_ref_clk), .i_req(req),
    .i_level(level), .o_sensor(i_sensor), .o_valid(i_sensor_valid));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [11:0] off_steps(input logic [7:0] c);
    return (c == 8'h03) ? 12'h010 : {2'b00, c, 2'b00};
  endfunction
  function automatic logic [11:0] ind_steps(input logic [7:0] c);
    return (c == 8'h03) ? 12'h008 : {3'b000, c, 1'b0};
  endfunction
  function automatic alzt_pkg::alzt_zone_t next_zone(
    input alzt_pkg::alzt_zone_t z, input logic [11:0] s);
    if (z == alzt_pkg::ALZT_BRIGHT)
      return (s < off_steps(cfg[0])) ? alzt_pkg::ALZT_OFFICE : z;
    if (z == alzt_pkg::ALZT_INDOOR)
      return (s > ind_steps(cfg[2]) + ind_steps(cfg[3])) ?
        alzt_pkg::ALZT_OFFICE : z;
    if (s < ind_steps(cfg[2]))
      return alzt_pkg::ALZT_INDOOR;
    if (s > off_steps(cfg[0]) + off_steps(cfg[1]))
      return alzt_pkg::ALZT_BRIGHT;
    return z;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(negedge i_ref_clk);
    i_reg_wr <= 1'b0;
    if (a >= 8'h34 && a <= 8'h37)
      cfg[a - 8'h34] = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(negedge i_ref_clk);
    i_reg_rd <= 1'b0;
    check({4'h0, o_reg_rdata}, {4'h0, exp});
  endtask
  task automatic sample(input logic [11:0] s);
    alzt_pkg::alzt_zone_t prev;
    prev = exp_zone;
    @(negedge i_ref_clk);
    req <= 1'b1;
    level <= s;
    @(negedge i_ref_clk);
    req <= 1'b0;
    exp_zone = next_zone(exp_zone, s);
    @(negedge i_ref_clk);
    check(o_zone, exp_zone);
    check(o_zone_change, exp_zone != prev);
    @(negedge i_ref_clk);
    check(o_zone_change, 12'h000);
  endtask
  task automatic do_reset();
    @(negedge i_ref_clk);
    i_reset_n = 1'b0;
    repeat (16) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    exp_zone = alzt_pkg::ALZT_BRIGHT;
    cfg = '{8'h00, 8'h00, 8'h00, 8'h00};
    check(o_zone, alzt_pkg::ALZT_BRIGHT);
    check(o_zone_change, 12'h000);
  endtask
  task automatic report_and_stop();
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end
  initial
  begin
    {i_reset_n, i_reg_wr, i_reg_rd, req} = 4'h0;
    {i_reg_addr, i_reg_wdata, level} = 28'h0;
    seed = 32'h38;
    do_reset();
    for (int a = 8'h34; a <= 8'h37; a++)
      rd(8'(a), 8'h00);
    wr(8'h38, 8'hFF);
    rd(8'h38, alzt_pkg::ALZT_UNMAPPED_RD);
    // Code 3 on all four settings pins the odd step of each scale.
    for (int a = 8'h34; a <= 8'h37; a++)
    begin
      wr(8'(a), 8'h03);
      rd(8'(a), 8'h03);
    end
    foreach (tbl[k])
      sample(tbl[k]);
    repeat (150)
    begin
      r = xs();
      if (r[2:0] == 3'h0)
        for (int k = 0; k < 4; k++)
        begin
          r = xs();
          wr(8'(8'h34 + k), r[3] ? corner[r[6:4] % 5] : r[15:8]);
          rd(8'(8'h34 + k), cfg[k]);
        end
      r = xs();
      case (r[1:0])
        2'd0: v = off_steps(cfg[0]);
        2'd1: v = off_steps(cfg[0]) + off_steps(cfg[1]);
        2'd2: v = ind_steps(cfg[2]);
        default: v = ind_steps(cfg[2]) + ind_steps(cfg[3]);
      endcase
      v = v + int'(r[5:3]) - 4;
      sample(12'((v < 0) ? 0 : v));
    end
    wr(8'h36, 8'h5A);
    do_reset();
    rd(8'h36, 8'h00);
    report_and_stop();
  end
endmodule // alzt_zone_tb
